// ===== aec_counter.sv
// one 20-bit event counter with its overflow latch and deferred write overflow
`timescale 1ns/1ps
`include "aec_defines.svh"
module aec_counter #(
  parameter int W = `AEC_CTR_W
) (
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic                  wr,
  input  wire logic [W-1:0]          wdata,
  input  wire logic [`AEC_INC_W-1:0] inc,
  input  wire logic                  int_clr,
  input  wire logic                  priv_exit,
  output logic      [W-1:0]          count_r,
  output logic                       carry_r,
  output logic                       latch_r,
  output logic                       defer_r
);
  logic         wr_seen_r;
  logic [W:0]   sum;
  logic         at_top;

  assign sum    = {1'b0, count_r} + {{(W + 1 - `AEC_INC_W){1'b0}}, inc};
  assign at_top = &count_r;

  // wrap modulo 2**W and keep the excess; counting goes on past overflow
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      count_r <= `AEC_CTR_RST;
      carry_r <= 1'b0;
    end else if (wr) begin
      count_r <= wdata;
      carry_r <= 1'b0;
    end else begin
      count_r <= sum[W-1:0];  // see RL13 see RL23
      carry_r <= sum[W];      // see RL23
    end
  end

  // only every second write since reset clears the latch; the writes in between leave it standing
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      latch_r   <= 1'b0;
      wr_seen_r <= 1'b0;
    end else begin
      if (!wr && sum[W])
        latch_r <= 1'b1;
      else if (wr && wr_seen_r)
        latch_r <= 1'b0;  // see RL18
      if (wr)
        wr_seen_r <= !wr_seen_r;
    end
  end

  // writing over a counter parked at the top fires later, even when disabled
  always_ff @(posedge mclk) begin
    if (!resetn)
      defer_r <= 1'b0;
    else if (wr && at_top)
      defer_r <= 1'b1;  // see RL16
    else if (int_clr || priv_exit)
      defer_r <= 1'b0;  // see RL16
  end

  AST_WRAP: assert property (@(posedge mclk) disable iff (!resetn) // see RL23
    !wr |=> count_r == $past(sum[W-1:0]) && carry_r == $past(sum[W]))
    else $error("counter did not wrap with carry");
  AST_LATCH_CLR: assert property (@(posedge mclk) disable iff (!resetn) // see RL18
    wr && wr_seen_r |=> !latch_r)
    else $error("second write did not clear the overflow latch");
  AST_LOAD: assert property (@(posedge mclk) disable iff (!resetn)
    wr |=> count_r == $past(wdata) && !carry_r)
    else $error("counter write not loaded");
endmodule : aec_counter

// ===== aec_defines.svh
// constants shared by the aggregate event counter block
`ifndef AEC_DEFINES_SVH
`define AEC_DEFINES_SVH
`define AEC_CTR_W        20
`define AEC_CTR_RST      20'h00000
`define AEC_INC_W        4
`define AEC_RET_STEP_MAX 4'h8
`define AEC_BKLG_W       6
`define AEC_BKLG_SAT     6'h3F
`define AEC_RD_PEND0_MAX 6'h04
`define AEC_EVT_LEAD     3
`define AEC_MODE_AGGR    1'h0
`define AEC_MODE_SAMPLE  1'h1
`endif

// ===== aec_pkg.sv
// types of the aggregate event counter block
package aec_pkg;
  typedef enum logic [1:0] {
    aec_sel_ret_cyc  = 2'h0,
    aec_sel_cyc_none = 2'h1,
    aec_sel_ret_miss = 2'h2,
    aec_sel_cyc_rply = 2'h3
  } aec_sel_t;
endpackage : aec_pkg

// ===== aec_src_model.sv
// event source model: retire, squash, board cache miss and replay trap traffic
`timescale 1ns/1ps
module aec_src_model (
  input  wire logic        mclk,
  input  wire logic        act,
  input  wire logic        burst,
  input  wire logic [31:0] rw,
  output logic      [3:0]  retire_count,
  output logic      [3:0]  squash_count,
  output logic             cache_miss,
  output logic             replay_trap,
  output int               ret_total,
  output int               miss_total,
  output int               trap_total
);
  logic [3:0] ret;
  logic [3:0] sq;
  // the core never retires more than 11 a cycle; squashed ones are a subset of them
  assign ret = burst ? 4'hB : (act ? 4'(rw[3:0] % 4'hC) : 4'h0);
  assign sq  = (burst || rw[5:4] != 2'h0 || 4'(rw[7:6]) > ret) ? 4'h0 : 4'(rw[7:6]);
  initial begin
    {retire_count, squash_count, cache_miss, replay_trap} = '0;
    {ret_total, miss_total, trap_total} = '0;
  end
  always @(posedge mclk) begin
    retire_count <= ret;
    squash_count <= sq;
    cache_miss   <= act & rw[8];
    replay_trap  <= act & rw[9];
    ret_total    <= ret_total + int'(ret - sq);
    miss_total   <= miss_total + int'(act & rw[8]);
    trap_total   <= trap_total + int'(act & rw[9]);
  end
endmodule : aec_src_model

// ===== aec_top.sv
// aggregate event counters: two 20-bit counters with input select and overflow interrupts
// Function
// RL1 - software writes counter zero only within 0 to 2**20-16.
// RL2 - software writes counter one only within 0 to 2**20-4.
// RL3 - mode select bit zero puts both counters in aggregate mode.
// RL4 - mode select bit one selects per-instruction sampling instead; sampling is not built here, and both counters hold.
// RL5 - input select field picks what each counter counts in aggregate mode.
// RL6 - a counter counts only with its enable and system or process enable.
// RL7 - retired-instruction counting adds at most eight per cycle.
// RL8 - retirements above eight are carried into later cycles, none lost; here the backlog saturates at 63 and a write clears it.
// RL9 - squashed instructions never count as retirements.
// RL10 - cycle counting adds exactly one per enabled cycle.
// RL11 - board cache misses count, and lead other inputs by three cycles.
// RL12 - each memory unit replay trap adds one.
// RL13 - a counter keeps counting after it overflows.
// RL14 - overflow with its irq enable set raises the matching pending bit.
// RL15 - interrupt delivery is held off in privileged code mode.
// RL16 - write at threshold raises overflow on privileged exit; clear cancels.
// RL17 - reset software loads both counters with zero first.
// RL18 - overflow latch clears only on a repeated write; write counters twice.
// RL19 - disabled counter one short of overflow blocks other interrupts.
// RL20 - counters may be read at any time and show the count.
// RL21 - reads while disabled may include a small pending increment.
// RL22 - handler reads the control register to find which counter overflowed.
// RL23 - overflow is carry out of bit 19; counter wraps keeping excess.
`timescale 1ns/1ps
`include "aec_defines.svh"
module aec_top #(
  parameter int W     = `AEC_CTR_W,
  parameter int LEAD  = `AEC_EVT_LEAD
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         ctl_wr,
  input  wire logic         ctl_mode_wdata,
  input  wire logic [1:0]   ctl_sel_wdata,
  input  wire logic [W-1:0] ctr0_wdata,
  input  wire logic [W-1:0] ctr1_wdata,
  input  wire logic         counter_zero_enable,
  input  wire logic         counter_one_enable,
  input  wire logic         system_count_enable,
  input  wire logic         process_count_enable,
  input  wire logic [1:0]   counter_irq_enable,
  input  wire logic         privileged_code_mode,
  input  wire logic         interrupt_clear_wr,
  input  wire logic [3:0]   retire_count,
  input  wire logic [3:0]   squash_count,
  input  wire logic         cache_miss,
  input  wire logic         replay_trap,
  input  wire logic         rd_req,
  output logic [W-1:0]      event_counter_zero,
  output logic [W-1:0]      event_counter_one,
  output logic              rd_valid_r,
  output logic [W-1:0]      rd_ctr0_r,
  output logic [W-1:0]      rd_ctr1_r,
  output logic [1:0]        ovf_latch_r,
  output logic [1:0]        counter_irq_pending,
  output logic              counter_irq_r,
  output logic              other_irq_block_r
);
  logic               mode_r;
  aec_pkg::aec_sel_t  sel_r;
  logic               priv_d_r;
  logic [3:0]         ret_pipe_r [LEAD];
  logic [LEAD-1:0]    rply_pipe_r;
  logic [`AEC_BKLG_W-1:0] bklg_r;
  logic [1:0]         pend_r;
  logic [1:0]         carry;
  logic [1:0]         latch;
  logic [1:0]         defer;
  logic [W-1:0]       cnt0;
  logic [W-1:0]       cnt1;

  // control fields of the control register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mode_r   <= `AEC_MODE_AGGR;
      sel_r    <= aec_pkg::aec_sel_ret_cyc;
      priv_d_r <= 1'b0;
    end else begin
      if (ctl_wr) begin
        mode_r <= ctl_mode_wdata;
        sel_r  <= aec_pkg::aec_sel_t'(ctl_sel_wdata);
      end
      priv_d_r <= privileged_code_mode;
    end
  end

  // sampling mode is not built here, so it just parks both counters
  wire aggr    = (mode_r == `AEC_MODE_AGGR);  // see RL3 see RL4
  wire any_en  = system_count_enable | process_count_enable;
  wire run0    = aggr & counter_zero_enable & any_en;  // see RL6
  wire run1    = aggr & counter_one_enable & any_en;   // see RL6
  wire priv_ex = priv_d_r & !privileged_code_mode;

  // squashed instructions are removed before anything is counted
  wire [3:0] net_ret = (retire_count > squash_count) ?
                       retire_count - squash_count : 4'h0;  // see RL9

  // retire and replay are delayed so the miss input leads them
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < LEAD; i++)
        ret_pipe_r[i] <= 4'h0;
      rply_pipe_r <= '0;
    end else begin
      ret_pipe_r[0] <= net_ret;  // see RL11
      for (int i = 1; i < LEAD; i++)
        ret_pipe_r[i] <= ret_pipe_r[i-1];
      rply_pipe_r <= {rply_pipe_r[LEAD-2:0], replay_trap};  // see RL11
    end
  end
  wire [3:0] ret_in  = ret_pipe_r[LEAD-1];
  wire       rply_in = rply_pipe_r[LEAD-1];

  // per-cycle increment capped at eight; the rest waits in a backlog
  wire sel0_ret = (sel_r == aec_pkg::aec_sel_ret_cyc) |
                  (sel_r == aec_pkg::aec_sel_ret_miss);  // see RL5
  wire [`AEC_BKLG_W:0] ret_tot = {1'b0, bklg_r} + {3'h0, ret_in};
  wire [3:0] ret_step = (ret_tot > {3'h0, `AEC_RET_STEP_MAX}) ?
                        `AEC_RET_STEP_MAX : ret_tot[3:0];  // see RL7
  wire [`AEC_BKLG_W:0] bklg_left = ret_tot - {3'h0, ret_step};
  wire count_ret = run0 & sel0_ret;

  always_ff @(posedge mclk) begin
    if (!resetn)
      bklg_r <= '0;
    else if (ctl_wr)
      bklg_r <= '0;
    else if (count_ret)
      bklg_r <= bklg_left[`AEC_BKLG_W] ? `AEC_BKLG_SAT :
                bklg_left[`AEC_BKLG_W-1:0];  // see RL8
  end

  // raw increments show what each counter would take this cycle
  wire [3:0] raw0 = sel0_ret ? ret_step : 4'h1;  // see RL10
  logic [3:0] raw1;
  always_comb begin
    case (sel_r)
      aec_pkg::aec_sel_ret_cyc:  raw1 = 4'h1;               // see RL10
      aec_pkg::aec_sel_ret_miss: raw1 = {3'h0, cache_miss}; // see RL11
      aec_pkg::aec_sel_cyc_rply: raw1 = {3'h0, rply_in};    // see RL12
      default:                   raw1 = 4'h0;
    endcase
  end
  wire [3:0] inc0 = run0 ? raw0 : 4'h0;
  wire [3:0] inc1 = run1 ? raw1 : 4'h0;

  aec_counter #(.W(W)) u_ctr0 (
    .mclk      (mclk),
    .resetn    (resetn),
    .wr        (ctl_wr),
    .wdata     (ctr0_wdata),
    .inc       (inc0),
    .int_clr   (interrupt_clear_wr),
    .priv_exit (priv_ex),
    .count_r   (cnt0),
    .carry_r   (carry[0]),
    .latch_r   (latch[0]),
    .defer_r   (defer[0])
  );
  aec_counter #(.W(W)) u_ctr1 (
    .mclk      (mclk),
    .resetn    (resetn),
    .wr        (ctl_wr),
    .wdata     (ctr1_wdata),
    .inc       (inc1),
    .int_clr   (interrupt_clear_wr),
    .priv_exit (priv_ex),
    .count_r   (cnt1),
    .carry_r   (carry[1]),
    .latch_r   (latch[1]),
    .defer_r   (defer[1])
  );
  assign event_counter_zero = cnt0;  // see RL20
  assign event_counter_one  = cnt1;  // see RL20
  assign ovf_latch_r        = latch; // see RL22

  // a read while stopped mirrors the quirk of a half-applied increment
  wire [`AEC_BKLG_W-1:0] pend0_cap = (bklg_r > `AEC_RD_PEND0_MAX) ?
                                     `AEC_RD_PEND0_MAX : bklg_r;
  wire [W-1:0] rd_add0 = run0 ? '0 :
                         (sel0_ret ? W'(pend0_cap) : W'(raw0));  // see RL21
  wire [W-1:0] rd_add1 = run1 ? '0 : W'(raw1);                  // see RL21

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_valid_r <= 1'b0;
      rd_ctr0_r  <= `AEC_CTR_RST;
      rd_ctr1_r  <= `AEC_CTR_RST;
    end else begin
      rd_valid_r <= rd_req;
      if (rd_req) begin
        rd_ctr0_r <= cnt0 + rd_add0;  // see RL20
        rd_ctr1_r <= cnt1 + rd_add1;
      end
    end
  end

  // a set in the same cycle as a clear wins, so no overflow is lost
  wire [1:0] fire = carry | (defer & {2{priv_ex}});          // see RL16
  wire [1:0] pend_set = fire & counter_irq_enable;           // see RL14
  always_ff @(posedge mclk) begin
    if (!resetn)
      pend_r <= 2'h0;
    else
      pend_r <= pend_set | (pend_r & {2{!interrupt_clear_wr}});  // see RL14
  end
  assign counter_irq_pending = pend_r;

  always_ff @(posedge mclk) begin
    if (!resetn)
      counter_irq_r <= 1'b0;
    else
      counter_irq_r <= (|pend_r) & !privileged_code_mode;  // see RL15
  end

  // a stopped counter sitting one step from overflow stalls other interrupts
  wire park0 = !run0 & (&cnt0);
  wire park1 = !run1 & (&cnt1);
  always_ff @(posedge mclk) begin
    if (!resetn)
      other_irq_block_r <= 1'b0;
    else
      other_irq_block_r <= park0 | park1;  // see RL19
  end

  sequence s_replay_in;
    run1 && sel_r == aec_pkg::aec_sel_cyc_rply && replay_trap;
  endsequence
  sequence s_quiet3;
    !ctl_wr && run1 && sel_r == aec_pkg::aec_sel_cyc_rply [*3];
  endsequence

  AST_SAMPLE_HOLD: assert property (@(posedge mclk) disable iff (!resetn) // see RL4
    !aggr && !ctl_wr |=> cnt0 == $past(cnt0) && cnt1 == $past(cnt1))
    else $error("counters moved outside aggregate mode");
  AST_EN_GATE: assert property (@(posedge mclk) disable iff (!resetn) // see RL6
    !run0 && !ctl_wr |=> cnt0 == $past(cnt0))
    else $error("disabled counter zero moved");
  AST_STEP_MAX: assert property (@(posedge mclk) disable iff (!resetn) // see RL7
    !ctl_wr |=> W'(cnt0 - $past(cnt0)) <= W'(8))
    else $error("counter zero stepped more than eight");
  AST_BKLG_KEEP: assert property (@(posedge mclk) disable iff (!resetn) // see RL8
    count_ret && !ctl_wr && !bklg_left[`AEC_BKLG_W]
    |=> W'(cnt0 - $past(cnt0)) + W'(bklg_r) == W'($past(ret_tot)))
    else $error("retirement lost");
  AST_CYC_ONE: assert property (@(posedge mclk) disable iff (!resetn) // see RL10
    run0 && !sel0_ret && !ctl_wr |=> cnt0 == $past(cnt0) + W'(1))
    else $error("cycle count did not add one");
  AST_SQUASH: assert property (@(posedge mclk) disable iff (!resetn) // see RL9
    retire_count <= squash_count |=> ret_pipe_r[0] == 4'h0)
    else $error("squashed instruction counted");
  AST_REPLAY_LAG: assert property (@(posedge mclk) disable iff (!resetn) // see RL12
    s_replay_in ##1 s_quiet3 |=> cnt1 == $past(cnt1) + W'(1))
    else $error("replay trap not counted after lag");
  AST_PEND_SET: assert property (@(posedge mclk) disable iff (!resetn) // see RL14
    carry[0] && counter_irq_enable[0] |=> pend_r[0])
    else $error("overflow did not raise pending");
  AST_PRIV_HOLD: assert property (@(posedge mclk) disable iff (!resetn) // see RL15
    privileged_code_mode |=> !counter_irq_r)
    else $error("interrupt delivered in privileged mode");
  AST_DEFER_FIRE: assert property (@(posedge mclk) disable iff (!resetn) // see RL16
    defer[0] && priv_ex && !carry[0] && counter_irq_enable[0] |=> pend_r[0] ##1 !defer[0])
    else $error("deferred overflow not raised on exit");
  AST_BLOCK: assert property (@(posedge mclk) disable iff (!resetn) // see RL19
    !run0 && (&cnt0) |=> other_irq_block_r)
    else $error("parked counter did not block");
  AST_LATCH2: assert property (@(posedge mclk) disable iff (!resetn) // see RL18
    latch[0] && ctl_wr ##1 !ctl_wr ##1 ctl_wr && !carry[0] |=> !latch[0])
    else $error("overflow latch survived a repeated write");
endmodule : aec_top

// ===== testbench.sv
// self-checking bench for the aggregate event counters
`timescale 1ns/1ps
module testbench;
  logic        mclk, resetn, ctl_wr, ctl_mode_wdata, interrupt_clear_wr, rd_req, act, burst;
  logic        privileged_code_mode, rd_valid_r, counter_irq_r, other_irq_block_r;
  logic        counter_zero_enable, counter_one_enable, system_count_enable;
  logic        process_count_enable, cache_miss, replay_trap;
  logic [1:0]  ctl_sel_wdata, counter_irq_enable, ovf_latch_r, counter_irq_pending;
  logic [3:0]  retire_count, squash_count, en, c;
  logic [19:0] ctr0_wdata, ctr1_wdata, event_counter_zero, event_counter_one;
  logic [19:0] rd_ctr0_r, rd_ctr1_r;
  logic [31:0] rw = 32'hC879F805;
  int          ret_total, miss_total, trap_total, n_fail, comparisons, n_wr, s0, s1, b0, b1;
  logic [3:0]  tbl [5] = '{4'h6, 4'h5, 4'h4, 4'h3, 4'hE};

  assign {counter_zero_enable, counter_one_enable, system_count_enable,
          process_count_enable} = en;

  aec_top u_aec_top (
    .mclk, .resetn, .ctl_wr, .ctl_mode_wdata, .ctl_sel_wdata, .ctr0_wdata, .ctr1_wdata,
    .counter_zero_enable, .counter_one_enable, .system_count_enable, .process_count_enable,
    .counter_irq_enable, .privileged_code_mode, .interrupt_clear_wr, .retire_count,
    .squash_count, .cache_miss, .replay_trap, .rd_req, .event_counter_zero,
    .event_counter_one, .rd_valid_r, .rd_ctr0_r, .rd_ctr1_r, .ovf_latch_r,
    .counter_irq_pending, .counter_irq_r, .other_irq_block_r
  );
  aec_src_model u_aec_src_model (
    .mclk, .act, .burst, .rw, .retire_count, .squash_count, .cache_miss, .replay_trap,
    .ret_total, .miss_total, .trap_total
  );

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  // counter one counts cycles only in select 0; counter zero in the odd selects
  function automatic logic [19:0] exp_ctr(input int one, input int s, input int st,
                                          input int n, input int ev);
    if (one == 1 && s == 1) return 20'(st);
    return 20'(st + (((one == 1) ? (s == 0) : (s % 2 == 1)) ? n : ev));
  endfunction : exp_ctr

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic wr(input logic m, input logic [1:0] s, input logic [19:0] a, b);
    // idle edge first, so back-to-back writes never toggle the strobe in one step
    step(1);
    {ctl_wr, ctl_mode_wdata, ctl_sel_wdata, ctr0_wdata, ctr1_wdata} = {1'b1, m, s, a, b};
    step(1);
    ctl_wr = 1'b0;
    n_wr++;
  endtask : wr

  task automatic clr_irq();
    interrupt_clear_wr = 1'b1;
    step(1);
    interrupt_clear_wr = 1'b0;
    step(2);
  endtask : clr_irq

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) rw <= xs(rw);

  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    complete_run();
  end

  initial begin
    {resetn, ctl_wr, ctl_mode_wdata, interrupt_clear_wr, rd_req, act, burst} = '0;
    {ctl_sel_wdata, counter_irq_enable, en, ctr0_wdata, ctr1_wdata} = '0;
    {n_fail, comparisons, n_wr} = '0;
    privileged_code_mode = 1'b1;
    step(5);
    resetn = 1'b1;
    check(event_counter_zero, 32'h0);
    check({ovf_latch_r, counter_irq_pending, counter_irq_r, rd_valid_r}, 32'h0);
    wr(1'b0, 2'h0, 20'h0, 20'h0);
    wr(1'b0, 2'h0, 20'h0, 20'h0);
    for (int s = 0; s < 4; s++) begin
      s0 = int'(rw % 32'h000FFFF1);
      s1 = int'(xs(rw) % 32'h000FFFFD);
      wr(1'b0, 2'(s), 20'(s0), 20'(s1));
      b0 = ret_total;
      b1 = (s == 2) ? miss_total : trap_total;
      en = (s % 2 == 1) ? 4'hD : 4'hE;
      act = 1'b1;
      step(40);
      act = 1'b0;
      // long drain so the retire delay line and backlog are empty before stopping
      step(20);
      en = 4'h0;
      step(2);
      b1 = ((s == 2) ? miss_total : trap_total) - b1;
      check(event_counter_zero, exp_ctr(0, s, s0, 60, ret_total - b0));
      check(event_counter_one, exp_ctr(1, s, s1, 60, b1));
    end
    for (int i = 0; i < 5; i++) begin
      c = tbl[i];
      wr(c[3], 2'h1, 20'h00100, 20'h0);
      en = {c[2], 1'b0, c[1:0]};
      step(10);
      en = 4'h0;
      step(1);
      check(event_counter_zero, (c[3:2] == 2'h1 && c[1:0] != 2'h0) ? 32'h10A : 32'h100);
    end
    wr(1'b0, 2'h0, 20'h00200, 20'h0);
    en = 4'hA;
    burst = 1'b1;
    step(1);
    burst = 1'b0;
    step(4);
    check(event_counter_zero, 32'h208);
    step(1);
    check(event_counter_zero, 32'h20B);
    en = 4'h0;
    step(4);
    rd_req = 1'b1;
    step(1);
    rd_req = 1'b0;
    for (int k = 0; k < 3 && rd_valid_r !== 1'b1; k++)
      step(1);
    check({rd_valid_r, rd_ctr0_r}, 32'h0010020B);
    check(rd_ctr1_r, 32'h1);
    step(1);
    check(rd_valid_r, 32'h0);
    counter_irq_enable = 2'h1;
    wr(1'b0, 2'h1, 20'hFFFF0, 20'h0);
    en = 4'hA;
    step(20);
    en = 4'h0;
    step(4);
    check(event_counter_zero, 32'h4);
    check({ovf_latch_r[0], counter_irq_pending, counter_irq_r}, 32'hA);
    privileged_code_mode = 1'b0;
    step(3);
    check(counter_irq_r, 32'h1);
    clr_irq();
    check({counter_irq_pending, counter_irq_r}, 32'h0);
    privileged_code_mode = 1'b1;
    b0 = 1;
    repeat (2) begin
      wr(1'b0, 2'h1, 20'h0, 20'h0);
      if (n_wr % 2 == 0) b0 = 0;
      check(ovf_latch_r[0], 32'(b0));
    end
    for (int k = 0; k < 2; k++) begin
      wr(1'b0, 2'h1, 20'hFFFFF, 20'h0);
      step(2);
      check(other_irq_block_r, 32'h1);
      wr(1'b0, 2'h1, 20'h0, 20'h0);
      step(2);
      check(counter_irq_pending, 32'h0);
      if (k == 1) clr_irq();
      privileged_code_mode = 1'b0;
      step(4);
      check(counter_irq_pending, 32'(1 - k));
      clr_irq();
      check({counter_irq_pending, counter_irq_r}, 32'h0);
      privileged_code_mode = 1'b1;
    end
    complete_run();
  end
endmodule : testbench
